//--- verilog/abpc_regs.svh
// Register indexes, field positions, reset values and widths of the path config bank
`ifndef ABPC_REGS_SVH
`define ABPC_REGS_SVH
`define ABPC_IDX_W          10
`define ABPC_IDX_PAGE       10'h000
`define ABPC_IDX_PATH       10'h06B
`define ABPC_IDX_BYPASS     10'h06C
`define ABPC_IDX_DACCUR     10'h06D
`define ABPC_IDX_RSV_LO     10'h06E
`define ABPC_IDX_RSV_HI     10'h07F
`define ABPC_IDX_IRQ_STAT   10'h080
`define ABPC_IDX_IRQ_MASK   10'h081
`define ABPC_PATH_RST       8'h00
`define ABPC_BYPASS_RST     8'h00
`define ABPC_DACCUR_RST     8'h00
`define ABPC_IRQ_RST        3'h0
`define ABPC_PATH_COEF_L    7
`define ABPC_PATH_COEF_R    6
`define ABPC_PATH_MIX_HI    5
`define ABPC_PATH_MIX_LO    4
`define ABPC_PATH_PFILT     3
`define ABPC_PATH_DET_OFF   2
`define ABPC_PATH_BUS_ERR   0
`define ABPC_DAC_HI         7
`define ABPC_DAC_LO         6
`define ABPC_IRQ_BUS_ERR    0
`define ABPC_IRQ_SHORT      1
`define ABPC_IRQ_DAC_RSV    2
`define ABPC_IRQ_W          3
`endif

//--- verilog/abpc_pkg.sv
// Types shared by the path config bank and its users
package abpc_pkg;
    typedef enum logic [1:0] {
        ABPC_MIX_DIG_DIG = 2'h0,
        ABPC_MIX_DIG_ANA = 2'h1,
        ABPC_MIX_ANA_DIG = 2'h2,
        ABPC_MIX_ANA_ANA = 2'h3
    } abpc_mix_e;
    typedef enum logic [1:0] {
        ABPC_DAC_DEFAULT = 2'h0,
        ABPC_DAC_PLUS50  = 2'h1,
        ABPC_DAC_RSV     = 2'h2,
        ABPC_DAC_PLUS100 = 2'h3
    } abpc_dac_cur_e;
    typedef struct packed {
        logic second_right_minus_input;
        logic second_right_plus_input;
        logic first_right_minus_input;
        logic first_right_plus_input;
        logic second_left_minus_input;
        logic second_left_plus_input;
        logic first_left_minus_input;
        logic first_left_plus_input;
    } abpc_bypass_s;
    typedef struct packed {
        logic left_programmed_coef;
        logic right_programmed_coef;
        logic left_analog_mic;
        logic right_analog_mic;
        logic prog_filter_attached;
    } abpc_adc_cfg_s;
endpackage : abpc_pkg

//--- verilog/abpc_top.sv
// APB register bank for ADC path, bus error status, passive bypass and DAC current
//
// Summary of operation
// R1: Left high_pass_stage uses programmed coefficients when set
// R2: Right high_pass_stage uses programmed coefficients when set
// R3: Two-bit field picks digital or analog microphones
// R4: Programmable filter attached only with DACs down
// R5: Detector runs and recovers errors while bit clear
// R6: Bus error status bit, cleared by reading
// R7: Reserved bits reset zero, write zeros only
// R8: Upper bypass bits close right side switches
// R9: Lower bypass bits close left side switches
// R10: Software avoids shorting two inputs onto one output
// R11: Two-bit field sets DAC reference current
// R12: Bank visible only while page zero active
// R13: Error bit held until its read completes
`include "abpc_regs.svh"
module abpc_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    input  wire logic                   bus_error_seen,
    input  wire logic                   dacs_powered_down,
    output logic                        bus_error_recover,
    output abpc_pkg::abpc_adc_cfg_s     adc_cfg,
    output abpc_pkg::abpc_bypass_s      bypass_switch,
    output abpc_pkg::abpc_dac_cur_e     dac_current
);
    import abpc_pkg::*;

    logic                       page_r;
    logic [7:2]                 path_r;
    logic                       bus_err_r;
    abpc_bypass_s               bypass_r;
    logic [7:0]                 daccur_r;
    logic [`ABPC_IRQ_W-1:0]     irq_stat_r;
    logic [`ABPC_IRQ_W-1:0]     irq_mask_r;
    logic                       irq_r;
    logic [31:0]                prdata_r;
    logic [31:0]                prdata_nxt;
    logic                       pready_r;
    logic                       pslverr_r;
    logic                       pslverr_nxt;
    logic                       recover_r;
    abpc_adc_cfg_s              adc_cfg_r;
    logic [`ABPC_IDX_W-1:0]     idx;
    logic                       sel_page;
    logic                       sel_path;
    logic                       sel_bypass;
    logic                       sel_daccur;
    logic                       sel_rsv;
    logic                       sel_stat;
    logic                       sel_mask;
    logic                       done;
    logic                       wr_done;
    logic                       rd_done;
    logic [`ABPC_IRQ_W-1:0]     irq_set;
    logic [7:0]                 wbyte;
    abpc_mix_e                  mix;

    assign idx   = paddr[11:2];
    assign wbyte = pwdata[7:0];

    // The path registers exist only on page zero; page one holds other banks
    always_comb
    begin
        sel_page   = (idx == `ABPC_IDX_PAGE);
        sel_path   = (idx == `ABPC_IDX_PATH) && !page_r;   // see R12
        sel_bypass = (idx == `ABPC_IDX_BYPASS) && !page_r; // see R12
        sel_daccur = (idx == `ABPC_IDX_DACCUR) && !page_r; // see R12
        sel_rsv    = (idx >= `ABPC_IDX_RSV_LO) && (idx <= `ABPC_IDX_RSV_HI);
        sel_rsv    = sel_rsv || (page_r && (idx >= 10'h001) && (idx <= `ABPC_IDX_RSV_HI));
        sel_stat   = (idx == `ABPC_IDX_IRQ_STAT);
        sel_mask   = (idx == `ABPC_IDX_IRQ_MASK);
    end

    // Read data and error are formed in the setup cycle so they leave a flop
    always_comb
    begin
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (paddr[1:0] != 2'h0)
        begin
            pslverr_nxt = 1'b1;
        end
        else if (sel_page)
        begin
            prdata_nxt = {31'h0000_0000, page_r};
        end
        else if (sel_path)
        begin
            prdata_nxt = {24'h00_0000, path_r, 1'b0, bus_err_r}; // see R6, R7
        end
        else if (sel_bypass)
        begin
            prdata_nxt = {24'h00_0000, bypass_r};
        end
        else if (sel_daccur)
        begin
            prdata_nxt = {24'h00_0000, daccur_r};
        end
        else if (sel_stat)
        begin
            prdata_nxt = {29'h0000_0000, irq_stat_r};
        end
        else if (sel_mask)
        begin
            prdata_nxt = {29'h0000_0000, irq_mask_r};
        end
        else if (!sel_rsv)
        begin
            pslverr_nxt = 1'b1;
        end
    end

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel && !penable;
            if (psel && !penable)
            begin
                pslverr_r <= pslverr_nxt;
                prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
            end
            else if (done)
            begin
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0000_0000;
            end
        end
    end

    assign done    = psel && penable && pready_r;
    assign wr_done = done && pwrite && !pslverr_r;
    assign rd_done = done && !pwrite && !pslverr_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            page_r <= 1'b0;
        end
        else if (wr_done && sel_page)
        begin
            page_r <= pwdata[0]; // see R12
        end
    end

    // Bit 1 and the status bit are read-only and never take write data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            path_r <= 6'(`ABPC_PATH_RST >> 2); // see R7
        end
        else if (wr_done && sel_path)
        begin
            path_r <= wbyte[7:2];
        end
    end

    // Only a bit that was returned as one is cleared, so an error landing
    // between setup and completion is kept; a new error also beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_err_r <= 1'b0;
        end
        else if (bus_error_seen && !path_r[`ABPC_PATH_DET_OFF])
        begin
            bus_err_r <= 1'b1; // see R5, R6
        end
        else if (rd_done && sel_path && prdata_r[`ABPC_PATH_BUS_ERR])
        begin
            bus_err_r <= 1'b0; // see R6, R13
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            recover_r <= 1'b0;
        end
        else
        begin
            recover_r <= bus_error_seen && !path_r[`ABPC_PATH_DET_OFF]; // see R5
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bypass_r <= `ABPC_BYPASS_RST;
        end
        else if (wr_done && sel_bypass)
        begin
            bypass_r <= wbyte; // see R8, R9
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            daccur_r <= `ABPC_DACCUR_RST; // see R7
        end
        else if (wr_done && sel_daccur)
        begin
            daccur_r <= wbyte; // see R11
        end
    end

    assign mix = abpc_mix_e'(path_r[`ABPC_PATH_MIX_HI:`ABPC_PATH_MIX_LO]);

    // Filter attach also depends on DAC power, so it follows that input one cycle behind
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_cfg_r <= '0;
        end
        else
        begin
            adc_cfg_r.left_programmed_coef  <= path_r[`ABPC_PATH_COEF_L]; // see R1
            adc_cfg_r.right_programmed_coef <= path_r[`ABPC_PATH_COEF_R]; // see R2
            adc_cfg_r.left_analog_mic  <= (mix == ABPC_MIX_ANA_DIG)
                                       || (mix == ABPC_MIX_ANA_ANA); // see R3
            adc_cfg_r.right_analog_mic <= (mix == ABPC_MIX_DIG_ANA)
                                       || (mix == ABPC_MIX_ANA_ANA); // see R3
            adc_cfg_r.prog_filter_attached <= path_r[`ABPC_PATH_PFILT]
                                           && dacs_powered_down; // see R4
        end
    end

    // Events: bus error, a bypass write that shorts two inputs, reserved DAC code
    always_comb
    begin
        irq_set = '0;
        irq_set[`ABPC_IRQ_BUS_ERR] = bus_error_seen && !path_r[`ABPC_PATH_DET_OFF];
        irq_set[`ABPC_IRQ_SHORT]   = wr_done && sel_bypass
                                   && ((wbyte[7] && wbyte[5]) || (wbyte[6] && wbyte[4])
                                   ||  (wbyte[3] && wbyte[1]) || (wbyte[2] && wbyte[0]));
        irq_set[`ABPC_IRQ_DAC_RSV] = wr_done && sel_daccur
                                   && (wbyte[`ABPC_DAC_HI:`ABPC_DAC_LO] == ABPC_DAC_RSV);
    end

    // Write one to clear; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= `ABPC_IRQ_RST;
        end
        else
        begin
            irq_stat_r <= irq_set | (irq_stat_r
                        & ~((wr_done && sel_stat) ? pwdata[`ABPC_IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_r <= `ABPC_IRQ_RST;
        end
        else if (wr_done && sel_mask)
        begin
            irq_mask_r <= pwdata[`ABPC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign irq               = irq_r;
    assign bus_error_recover = recover_r;
    assign adc_cfg           = adc_cfg_r;
    assign bypass_switch     = bypass_r;
    assign dac_current       = abpc_dac_cur_e'(daccur_r[`ABPC_DAC_HI:`ABPC_DAC_LO]);
endmodule : abpc_top

//--- verif/abpc_top_asserts.sv
// Checker of bus timing and output causes for the path config bank
module abpc_top_asserts
    import abpc_pkg::*;
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            bus_error_seen,
    input wire logic            dacs_powered_down,
    input wire logic            bus_error_recover,
    input wire abpc_adc_cfg_s   adc_cfg,
    input wire abpc_bypass_s    bypass_switch,
    input wire abpc_dac_cur_e   dac_current
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no pready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready too long");
    property p_rdz; !pready |-> prdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("prdata outside access");
    property p_mis; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_mis: assert property (p_mis) else $error("misaligned not refused");
    property p_rec; bus_error_recover |-> $past(bus_error_seen); endproperty
    a_rec: assert property (p_rec) else $error("recover without error");
    property p_byp; $changed(bypass_switch) |-> $past(pready && pwrite); endproperty
    a_byp: assert property (p_byp) else $error("bypass moved unwritten");
    property p_dac; $changed(dac_current) |-> $past(pready && pwrite); endproperty
    a_dac: assert property (p_dac) else $error("dac current moved unwritten");
    // Config follows the register one cycle later, so the write lies two samples back
    property p_coef; $changed(adc_cfg[4:1]) |-> $past(pready && pwrite, 2); endproperty
    a_coef: assert property (p_coef) else $error("adc config moved unwritten");
    property p_pf; adc_cfg.prog_filter_attached |-> $past(dacs_powered_down); endproperty
    a_pf: assert property (p_pf) else $error("filter attached with dacs up");
    c_rec: cover property (bus_error_recover);
    c_err: cover property (pslverr);
    c_pf: cover property (adc_cfg.prog_filter_attached);
endmodule : abpc_top_asserts

bind abpc_top abpc_top_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .bus_error_seen, .dacs_powered_down, .bus_error_recover,
    .adc_cfg, .bypass_switch, .dac_current);

//--- verif/abpc_host.sv
// Control bus host model issuing APB transfers into the bank
module abpc_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look still valid
        pwdata <= ~d;
    endtask : xfer
endmodule : abpc_host

//--- verif/adc_path_bypass_config_regs_test.sv
// Self-checking bench for the path config bank
`include "abpc_regs.svh"
module adc_path_bypass_config_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import abpc_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic          bus_error_seen, dacs_powered_down, bus_error_recover;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, q;
    abpc_adc_cfg_s adc_cfg;
    abpc_bypass_s  bypass_switch;
    abpc_dac_cur_e dac_current;
    int            errors, checks_done;
    localparam logic [11:0] A_PG = 12'h000, A_IST = 12'h200, A_IMK = 12'h204;
    localparam logic [11:0] A_PATH = {`ABPC_IDX_PATH, 2'h0};
    localparam logic [11:0] A_BYP = {`ABPC_IDX_BYPASS, 2'h0}, A_DAC = {`ABPC_IDX_DACCUR, 2'h0};
    abpc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .bus_error_seen, .dacs_powered_down, .bus_error_recover,
        .adc_cfg, .bypass_switch, .dac_current);
    abpc_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] x, input string n);
        host_u.xfer(1'b0, a, 32'h0, q, e);
        chk(n, x, q);
    endtask : rd
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle
    task pulse;
        @(posedge pclk);
        bus_error_seen <= 1'b1;
        @(posedge pclk);
        bus_error_seen <= 1'b0;
        #1;
    endtask : pulse
    task t_path;
        static logic [7:0] w [3] = '{8'h80, 8'h40, 8'h08};
        static logic [4:0] x [3] = '{5'h10, 5'h08, 5'h01};
        // Reserved bit 1 is written as zero; the one in bit 0 must not land
        wr(A_PATH, 32'hFD);
        rd(A_PATH, 32'hFC, "path readback");
        settle;
        chk("cfg dacs up", 32'h1E, adc_cfg);
        @(posedge pclk);
        dacs_powered_down <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(A_PATH, w[i]);
            settle;
            chk("cfg bit", x[i], adc_cfg);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(A_PATH, i << 4);
            settle;
            chk("mix", i, {adc_cfg.left_analog_mic, adc_cfg.right_analog_mic});
        end
        $display("t_path done");
    endtask : t_path
    task t_err;
        wr(A_PATH, 32'h0);
        pulse;
        chk("recover", 32'h1, bus_error_recover);
        settle;
        rd(A_PATH, 32'h1, "error set");
        rd(A_PATH, 32'h0, "error cleared");
        wr(A_PATH, 32'h4);
        pulse;
        chk("recover off", 32'h0, bus_error_recover);
        settle;
        rd(A_PATH, 32'h4, "detector off");
        $display("t_err done");
    endtask : t_err
    task t_irq;
        rd(A_IST, 32'h1, "stat");
        wr(A_IMK, 32'h7);
        settle;
        chk("irq on", 32'h1, irq);
        wr(A_IST, 32'h1);
        settle;
        chk("irq clear", 32'h0, irq);
        // Deliberate short, only to prove the event flag
        wr(A_BYP, 32'hA0);
        settle;
        rd(A_IST, 32'h2, "short stat");
        wr(A_IMK, 32'h0);
        settle;
        chk("irq masked", 32'h0, irq);
        wr(A_IST, 32'h2);
        rd(A_IST, 32'h0, "stat w1c");
        $display("t_irq done");
    endtask : t_irq
    task t_byp_dac;
        static logic [1:0] c [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 8; i++)
        begin
            wr(A_BYP, 32'h1 << i);
            settle;
            chk("bypass", 32'h1 << i, bypass_switch);
        end
        rd(A_BYP, 32'h80, "bypass readback");
        for (int i = 0; i < 4; i++)
        begin
            wr(A_DAC, {c[i], 6'h0});
            settle;
            chk("dac", c[i], dac_current);
        end
        rd(A_IST, 32'h4, "dac rsv stat");
        $display("t_byp_dac done");
    endtask : t_byp_dac
    task t_page;
        wr(A_PG, 32'h1);
        rd(A_PG, 32'h1, "page readback");
        rd(A_PATH, 32'h0, "page1 path");
        wr(A_BYP, 32'hFF);
        wr(A_PG, 32'h0);
        rd(A_BYP, 32'h80, "page1 write");
        host_u.xfer(1'b0, 12'h1AD, 32'h0, q, e);
        chk("misaligned", 32'h1, e);
        host_u.xfer(1'b0, 12'h300, 32'h0, q, e);
        chk("unmapped", 32'h1, e);
        $display("t_page done");
    endtask : t_page
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {presetn, bus_error_seen, dacs_powered_down, errors, checks_done} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PATH, 32'h0, "path reset");
        rd(A_DAC, 32'h0, "dac reset");
        rd(A_BYP, 32'h0, "bypass reset");
        t_path;
        t_err;
        t_irq;
        t_byp_dac;
        t_page;
        report_and_stop;
    end
    // Whole run is well under this span
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        report_and_stop;
    end
endmodule : adc_path_bypass_config_regs_test
